// ==== src/cssel_pkg.sv ====
package cssel_pkg;
  localparam logic [6:0] CSSEL_FN_SRC_SWITCH = 7'h43;
  localparam logic [6:0] CSSEL_FN_PID_DIR    = 7'h40;
  localparam logic [6:0] CSSEL_FN_PID_ICLR   = 7'h48;
  localparam int         CSSEL_NUM_TERMS     = 5;
  localparam logic [1:0] CSSEL_PWS_RUN_WRITE = 2'h2;
  localparam logic       CSSEL_OP_NET        = 1'h0;
  localparam logic       CSSEL_OP_EXT        = 1'h1;
  localparam logic [1:0] CSSEL_SPD_NET       = 2'h0;
  localparam logic [1:0] CSSEL_SPD_EXT1      = 2'h1;
  localparam logic [1:0] CSSEL_SPD_EXT2      = 2'h2;
  localparam logic       CSSEL_OP_RST        = 1'h0;
  localparam logic [1:0] CSSEL_SPD_RST       = 2'h0;
  localparam logic       CSSEL_SWITCH_RST    = 1'h1;
endpackage

// ==== src/cssel_top.sv ====
`timescale 1ns/1ps
`default_nettype none
// Operation
// R01: switch input acts only in network mode
// R02: function code 67 assigns switch terminal
// R03: switch off means terminals only
// R04: unassigned switch follows both source settings
// R05: switch level change applied only at stop
// R06: switch off blocks communication reset requests
// R07: write select 2 defers source setting changes
// R08: network-sourced takes communication, ignores terminal
// R09: external takes terminal, ignores communication
// R10: combined accepts terminal or communication
// R11: pid direction follows speed source setting
// R12: pid integral clear follows speed source setting
// R13: start source gates start, speed gates frequency
// R14: switch on follows settings as unassigned
module cssel_top
  import cssel_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        net_mode,
  input  wire logic        running,
  input  wire logic        op_cmd_source_setting,
  input  wire logic [1:0]  speed_cmd_source_setting,
  input  wire logic [1:0]  param_write_select,
  input  wire logic [34:0] input_terminal_function_select,
  input  wire logic [4:0]  term_pins,
  input  wire logic        term_fwd,
  input  wire logic        term_rev,
  input  wire logic        term_freq_sel,
  input  wire logic        term_out_stop,
  input  wire logic        term_reset,
  input  wire logic        com_fwd,
  input  wire logic        com_rev,
  input  wire logic        com_freq_sel,
  input  wire logic        com_out_stop,
  input  wire logic        com_reset,
  input  wire logic        com_pid_dir,
  input  wire logic        com_pid_iclr,
  output logic             start_src_ext,
  output logic             speed_src_ext,
  output logic             fwd_cmd,
  output logic             rev_cmd,
  output logic             freq_sel_cmd,
  output logic             out_stop_cmd,
  output logic             reset_req,
  output logic             pid_direction_switch,
  output logic             pid_integral_clear
);

  // pins are asynchronous: two flops before any decode reads them
  logic [4:0] pin_s1_reg;
  logic [4:0] pin_s2_reg;

  // effective sources: what the command routing actually obeys
  logic       op_eff_reg;
  logic       op_eff_next;
  logic [1:0] spd_eff_reg;
  logic [1:0] spd_eff_next;
  logic       sw_eff_reg;
  logic       sw_eff_next;

  logic [6:0] code_t0;
  logic [6:0] code_t1;
  logic [6:0] code_t2;
  logic [6:0] code_t3;
  logic [6:0] code_t4;
  logic [4:0] sw_slot;
  logic [4:0] dir_slot;
  logic [4:0] icl_slot;

  logic       sw_assigned;
  logic       sw_level;
  logic       sw_now;
  logic       hold_cfg;
  logic       defer_cfg;
  logic       sw_active;
  logic       op_ext;
  logic       spd_ext;
  logic       start_ext;
  logic       speed_ext;
  logic       pid_term;
  logic       icl_term;
  logic       com_reset_ok;

  logic       fwd_next;
  logic       rev_next;
  logic       freq_sel_next;
  logic       out_stop_next;
  logic       reset_next;
  logic       pid_dir_next;
  logic       pid_iclr_next;

  // each terminal owns a 7-bit function code field
  function automatic logic [6:0] field_code(input logic [34:0] sel, input int idx);
    return sel[idx*7 +: 7];
  endfunction

  // any matched slot whose synchronised pin is high
  function automatic logic pin_hit(input logic [4:0] slot, input logic [4:0] pins);
    return |(slot & pins);
  endfunction

  // function code per terminal slot
  assign code_t0 = field_code(input_terminal_function_select, 0);
  assign code_t1 = field_code(input_terminal_function_select, 1);
  assign code_t2 = field_code(input_terminal_function_select, 2);
  assign code_t3 = field_code(input_terminal_function_select, 3);
  assign code_t4 = field_code(input_terminal_function_select, 4);

  // a slot matches by its code alone; the pin level is looked at later
  assign sw_slot[0] = (code_t0 == CSSEL_FN_SRC_SWITCH); // R02
  assign sw_slot[1] = (code_t1 == CSSEL_FN_SRC_SWITCH); // R02
  assign sw_slot[2] = (code_t2 == CSSEL_FN_SRC_SWITCH); // R02
  assign sw_slot[3] = (code_t3 == CSSEL_FN_SRC_SWITCH); // R02
  assign sw_slot[4] = (code_t4 == CSSEL_FN_SRC_SWITCH); // R02

  assign dir_slot[0] = (code_t0 == CSSEL_FN_PID_DIR); // R11
  assign dir_slot[1] = (code_t1 == CSSEL_FN_PID_DIR); // R11
  assign dir_slot[2] = (code_t2 == CSSEL_FN_PID_DIR); // R11
  assign dir_slot[3] = (code_t3 == CSSEL_FN_PID_DIR); // R11
  assign dir_slot[4] = (code_t4 == CSSEL_FN_PID_DIR); // R11

  assign icl_slot[0] = (code_t0 == CSSEL_FN_PID_ICLR); // R12
  assign icl_slot[1] = (code_t1 == CSSEL_FN_PID_ICLR); // R12
  assign icl_slot[2] = (code_t2 == CSSEL_FN_PID_ICLR); // R12
  assign icl_slot[3] = (code_t3 == CSSEL_FN_PID_ICLR); // R12
  assign icl_slot[4] = (code_t4 == CSSEL_FN_PID_ICLR); // R12

  assign sw_assigned = |sw_slot; // R02
  assign sw_level    = pin_hit(sw_slot, pin_s2_reg); // R02
  // an unassigned switch acts as held on, so the settings rule alone
  assign sw_now      = sw_assigned ? sw_level : 1'h1; // R04 R14

  // settings and switch level reach the routing only while stopped
  assign hold_cfg     = running; // R05
  // write select 2 accepts run-time writes, but they still wait for stop
  assign defer_cfg    = running && (param_write_select == CSSEL_PWS_RUN_WRITE); // R07
  assign op_eff_next  = (hold_cfg || defer_cfg) ? op_eff_reg : op_cmd_source_setting; // R07
  assign spd_eff_next = (hold_cfg || defer_cfg) ? spd_eff_reg : speed_cmd_source_setting; // R07
  assign sw_eff_next  = hold_cfg ? sw_eff_reg : sw_now; // R05

  // the switch has no say outside network operation
  assign sw_active    = net_mode && !sw_eff_reg; // R01 R03
  assign op_ext       = (op_eff_reg == CSSEL_OP_EXT); // R04 R14
  assign spd_ext      = (spd_eff_reg != CSSEL_SPD_NET); // R04 R14
  assign start_ext    = sw_active || op_ext; // R13
  assign speed_ext    = sw_active || spd_ext; // R13

  assign pid_term     = pin_hit(dir_slot, pin_s2_reg); // R11
  assign icl_term     = pin_hit(icl_slot, pin_s2_reg); // R12
  assign com_reset_ok = com_reset && !sw_active; // R06

  assign fwd_next      = start_ext ? term_fwd : com_fwd; // R08 R09
  assign rev_next      = start_ext ? term_rev : com_rev; // R08 R09
  assign freq_sel_next = speed_ext ? term_freq_sel : com_freq_sel; // R08 R09 R13
  assign out_stop_next = term_out_stop || com_out_stop; // R10
  assign reset_next    = term_reset || com_reset_ok; // R06
  assign pid_dir_next  = speed_ext ? pid_term : com_pid_dir; // R11
  assign pid_iclr_next = speed_ext ? icl_term : com_pid_iclr; // R12

  // first stage is read only by the second: no decode sees a metastable flop
  always_ff @(posedge clk) begin
    pin_s1_reg <= term_pins;
  end

  always_ff @(posedge clk) begin
    pin_s2_reg <= pin_s1_reg;
  end

  // start source setting, frozen while running
  always_ff @(posedge clk) begin
    if (rst) begin
      op_eff_reg <= CSSEL_OP_RST;
    end
    else begin
      op_eff_reg <= op_eff_next; // R07
    end
  end

  // speed source setting, frozen while running
  always_ff @(posedge clk) begin
    if (rst) begin
      spd_eff_reg <= CSSEL_SPD_RST;
    end
    else begin
      spd_eff_reg <= spd_eff_next; // R07
    end
  end

  // switch level, applied only at stop; reset leaves it on
  always_ff @(posedge clk) begin
    if (rst) begin
      sw_eff_reg <= CSSEL_SWITCH_RST;
    end
    else begin
      sw_eff_reg <= sw_eff_next; // R05
    end
  end

  // 1: start commands come from the terminals
  always_ff @(posedge clk) begin
    if (rst) begin
      start_src_ext <= 1'h0;
    end
    else begin
      start_src_ext <= start_ext; // R13
    end
  end

  // 1: speed commands come from the terminals
  always_ff @(posedge clk) begin
    if (rst) begin
      speed_src_ext <= 1'h0;
    end
    else begin
      speed_src_ext <= speed_ext; // R13
    end
  end

  // forward run follows the start source
  always_ff @(posedge clk) begin
    if (rst) begin
      fwd_cmd <= 1'h0;
    end
    else begin
      fwd_cmd <= fwd_next; // R08 R09
    end
  end

  // reverse run follows the start source
  always_ff @(posedge clk) begin
    if (rst) begin
      rev_cmd <= 1'h0;
    end
    else begin
      rev_cmd <= rev_next; // R08 R09
    end
  end

  // frequency selection follows the speed source
  always_ff @(posedge clk) begin
    if (rst) begin
      freq_sel_cmd <= 1'h0;
    end
    else begin
      freq_sel_cmd <= freq_sel_next; // R13
    end
  end

  // combined: neither side can mask the other's stop
  always_ff @(posedge clk) begin
    if (rst) begin
      out_stop_cmd <= 1'h0;
    end
    else begin
      out_stop_cmd <= out_stop_next; // R10
    end
  end

  // a terminal reset is always honoured
  always_ff @(posedge clk) begin
    if (rst) begin
      reset_req <= 1'h0;
    end
    else begin
      reset_req <= reset_next; // R06
    end
  end

  // loop direction follows the speed source
  always_ff @(posedge clk) begin
    if (rst) begin
      pid_direction_switch <= 1'h0;
    end
    else begin
      pid_direction_switch <= pid_dir_next; // R11
    end
  end

  // integral clear follows the speed source
  always_ff @(posedge clk) begin
    if (rst) begin
      pid_integral_clear <= 1'h0;
    end
    else begin
      pid_integral_clear <= pid_iclr_next; // R12
    end
  end
endmodule
`default_nettype wire

// ==== src/unused_placeholder_none.sv ====
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ==== sim/cssel_assertions.sv ====
`timescale 1ns/1ps
`default_nettype none
module cssel_chk (
  input wire logic clk, rst, running, net_mode, term_fwd, com_fwd, term_rev, com_rev,
  input wire logic term_freq_sel, com_freq_sel, term_out_stop, com_out_stop,
  input wire logic com_pid_dir, com_pid_iclr, start_src_ext, speed_src_ext,
  input wire logic fwd_cmd, rev_cmd, freq_sel_cmd, out_stop_cmd, reset_req,
  input wire logic pid_direction_switch, pid_integral_clear
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // a stable source flag means the select did not move under the command
  AST_FWD: assert property (!$past(rst) && $stable(start_src_ext) |->
    fwd_cmd == $past(start_src_ext ? term_fwd : com_fwd)) else $error("fwd");
  AST_REV: assert property (!$past(rst) && $stable(start_src_ext) |->
    rev_cmd == $past(start_src_ext ? term_rev : com_rev)) else $error("rev");
  AST_FREQ: assert property (!$past(rst) && $stable(speed_src_ext) |->
    freq_sel_cmd == $past(speed_src_ext ? term_freq_sel : com_freq_sel)) else $error("freq");
  AST_OSTOP: assert property (!$past(rst) |->
    out_stop_cmd == $past(term_out_stop | com_out_stop)) else $error("out stop");
  AST_FREEZE: assert property (running && $past(running) && $past(running, 2) &&
    ($past(net_mode) == $past(net_mode, 2)) |->
    $stable(start_src_ext) && $stable(speed_src_ext)) else $error("source moved");
  AST_RST: assert property (disable iff (1'b0) rst |=>
    !fwd_cmd && !reset_req && !start_src_ext) else $error("reset");
  AST_PDIR: assert property (!$past(rst) && !speed_src_ext && !$past(speed_src_ext) |->
    pid_direction_switch == $past(com_pid_dir)) else $error("pid dir");
  AST_PCLR: assert property (!$past(rst) && !speed_src_ext && !$past(speed_src_ext) |->
    pid_integral_clear == $past(com_pid_iclr)) else $error("pid clear");
  cover property (start_src_ext && !speed_src_ext);
  cover property (running && reset_req);
  cover property ($fell(speed_src_ext));
endmodule
bind cssel_top cssel_chk u_chk (.*);
`default_nettype wire

// ==== sim/cssel_far.sv ====
`timescale 1ns/1ps
`default_nettype none
module cssel_far (
  input  wire logic        clk,
  input  wire logic [11:0] p,
  output logic      [11:0] q
);
  // terminals and master's commands start low; both follow p one cycle late, just after the edge
  initial q = '0;
  always @(posedge clk) q <= #1 p;
endmodule
`default_nettype wire

// ==== sim/tb_command_source_select.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_command_source_select;
  import cssel_pkg::*;
  logic clk = 0, rst = 1, network_sourced = 1, run = 0, op = 0;
  logic [1:0] spd = 0, pws = 0;
  logic [34:0] fs = 0;
  logic [4:0] pins = 0;
  logic [11:0] p = 0, q;
  logic [8:0] o;
  int err_total = 0, checks = 0, cyc = 0;
  always #10 clk = ~clk;
  cssel_far far (.clk(clk), .p(p), .q(q));
  cssel_top dut (.clk(clk), .rst(rst), .net_mode(network_sourced), .running(run),
    .op_cmd_source_setting(op), .speed_cmd_source_setting(spd),
    .param_write_select(pws), .input_terminal_function_select(fs), .term_pins(pins),
    .term_fwd(q[0]), .term_rev(q[1]), .term_freq_sel(q[2]), .term_out_stop(q[3]),
    .term_reset(q[4]), .com_fwd(q[5]), .com_rev(q[6]), .com_freq_sel(q[7]),
    .com_out_stop(q[8]), .com_reset(q[9]), .com_pid_dir(q[10]), .com_pid_iclr(q[11]),
    .start_src_ext(o[8]), .speed_src_ext(o[7]), .fwd_cmd(o[6]), .rev_cmd(o[5]),
    .freq_sel_cmd(o[4]), .out_stop_cmd(o[3]), .reset_req(o[2]),
    .pid_direction_switch(o[1]), .pid_integral_clear(o[0]));
  task complete_run;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // six cycles cover the pin synchroniser, the latch and the output flop
  task ck(input logic [8:0] e);
    repeat (6) @(posedge clk);
    #1 checks++;
    if (o !== e) begin
      err_total++;
      $display("ERROR %0t got %h want %h", $time, o, e);
    end
    $display("test %0d done", checks);
  endtask
  always @(posedge clk) if (++cyc == 500) begin
    err_total++;
    complete_run;
  end
  initial begin
    repeat (2) @(posedge clk);
    #1 rst = 0;
    op = 1;
    p = 12'hd83;
    fs = {14'h0, CSSEL_FN_PID_ICLR, CSSEL_FN_PID_DIR, 7'h00};
    ck(9'h17b);
    op = 0;
    fs[6:0] = CSSEL_FN_SRC_SWITCH;
    pins = 5'h02;
    p = 12'h201;
    ck(9'h1c2);
    pins = 5'h03;
    ck(9'h004);
    run = 1;
    pws = CSSEL_PWS_RUN_WRITE;
    op = 1;
    spd = 2;
    pins = 5'h02;
    ck(9'h004);
    run = 0;
    ck(9'h1c2);
    pins = 5'h03;
    p = 12'h001;
    ck(9'h1c2);
    network_sourced = 0;
    op = 0;
    spd = 0;
    pins = 5'h02;
    ck(9'h000);
    complete_run;
  end
endmodule
`default_nettype wire
